/* File: design/ppc_port_ctrl.sv */
`timescale 1ns/1ps
`include "ppc_map.svh"
// Notes on behaviour
// - The timer port has four lines, each set as input or output.
// - A timer line has a pull-up when enabled, in any direction.
// - In control mode each timer line clocks its timer channel.
// - In control mode each timer line is driven by its timer output.
// - Each real-time line chooses port or control mode on its own.
// - In port mode each real-time line follows its own direction bit.
// - A real-time line has a pull-up when enabled, in any direction.
// - Real-time control lines load prepared data only on the trigger.
// - Reads of real-time lines in control mode return zero.
// - The two analog lines change mode together as a pair.
// - In port mode each analog line follows its own direction bit.
// - The analog lines have no pull-up and no pull-up enables.
// - In control mode the converter drives the analog lines; reads undefined.
// - A low level on the reset pin resets the logic, high lets it run.
module ppc_port_ctrl #(
   parameter int TMR_W = `PPC_TMR_W,
   parameter int RTP_W = `PPC_RTP_W,
   parameter int ANA_W = `PPC_ANA_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sysResetN,
   output logic chipReset,
   // Timer port; direction bit 1 = input
   input wire logic [TMR_W-1:0] timerDir,
   input wire logic [TMR_W-1:0] timerLatch,
   input wire logic [TMR_W-1:0] timerPullUpEn,
   input wire logic [TMR_W-1:0] timerCtrlMode,
   input wire logic [TMR_W-1:0] timer_wave_out,
   output logic [TMR_W-1:0] timer_ext_clk_in,
   input wire logic [TMR_W-1:0] timerPortIn,
   output logic [TMR_W-1:0] timerPortOut,
   output logic [TMR_W-1:0] timerPortOe,
   output logic [TMR_W-1:0] timerPortPullUp,
   output logic [TMR_W-1:0] timerReadData,
   // Real-time output port
   input wire logic [RTP_W-1:0] rtDir,
   input wire logic [RTP_W-1:0] rtLatch,
   input wire logic [RTP_W-1:0] rtPullUpEn,
   input wire logic [RTP_W-1:0] rtCtrlMode,
   input wire logic [RTP_W-1:0] rtPrepData,
   input wire logic rtTrigger,
   input wire logic [RTP_W-1:0] realtimePortIn,
   output logic [RTP_W-1:0] realtimePortOut,
   output logic [RTP_W-1:0] realtimePortOe,
   output logic [RTP_W-1:0] realtimePortPullUp,
   output logic [RTP_W-1:0] rtReadData,
   // Analog output port, no pull-ups
   input wire logic [ANA_W-1:0] analog_port_dir_bit,
   input wire logic [ANA_W-1:0] anaLatch,
   input wire logic anaCtrlMode,
   input wire logic [ANA_W-1:0] analogPortIn,
   output logic [ANA_W-1:0] analogPortOut,
   output logic [ANA_W-1:0] analogPortOe,
   output logic [ANA_W-1:0] dacOutEn,
   output logic [ANA_W-1:0] anaReadData
);
   logic [RTP_W-1:0] trig_sync_out_r;
   logic [TMR_W-1:0] tmrIn_r;
   logic [RTP_W-1:0] rtIn_r;
   logic [ANA_W-1:0] anaIn_r;
   logic sysRstSeen_r;
   logic sysRstSeen_nxt;
   logic [RTP_W-1:0] trig_sync_out_nxt;
   logic [TMR_W-1:0] tmrCtl;
   logic [RTP_W-1:0] rtCtl;
   logic anaCtl;

   // Every port needs at least one line
   generate
      if (TMR_W < 1) begin : gBadTmr
         $error("ppc_port_ctrl: TMR_W must be at least one");
      end

      if (RTP_W < 1) begin : gBadRtp
         $error("ppc_port_ctrl: RTP_W must be at least one");
      end

      if (ANA_W < 1) begin : gBadAna
         $error("ppc_port_ctrl: ANA_W must be at least one");
      end
   endgenerate

   // Control mode is refused while a reset request is pending
   function automatic logic in_ctrl(
      input logic modeBit,
      input logic rstSeen
   );
      ppc_pkg::ppc_mode_t mode;
      mode = ppc_pkg::ppc_mode_t'(modeBit);
      return (mode == ppc_pkg::PPC_CTRL_MODE) && !rstSeen;
   endfunction

   // Direction bit 1 means input; control mode always drives
   function automatic logic drive_en(
      input logic ctl,
      input logic dirIn
   );
      logic en;
      en = ctl | ~dirIn;
      return en;
   endfunction

   // Driven lines read back their own value, released lines the pin sample
   function automatic logic read_back(
      input logic oe,
      input logic drv,
      input logic pin
   );
      if (oe) begin
         return drv;
      end
      return pin;
   endfunction

   // Reset pin is a level request, sampled like any other pin
   always_comb begin
      sysRstSeen_nxt = ~sysResetN;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sysRstSeen_r <= `PPC_CHIPRST_RST;
      end else begin
         sysRstSeen_r <= sysRstSeen_nxt;
      end
   end
   assign chipReset = sysRstSeen_r;

   // One sample per edge; read data of input lines lags the pin by a cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tmrIn_r <= {TMR_W{`PPC_PIN_RST}};
      end else begin
         tmrIn_r <= timerPortIn;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rtIn_r <= {RTP_W{`PPC_PIN_RST}};
      end else begin
         rtIn_r <= realtimePortIn;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         anaIn_r <= {ANA_W{`PPC_PIN_RST}};
      end else begin
         anaIn_r <= analogPortIn;
      end
   end

   // Held until the next trigger or a reset request, so software may prepare data at leisure
   always_comb begin
      trig_sync_out_nxt = trig_sync_out_r;
      if (sysRstSeen_r) begin
         trig_sync_out_nxt = {RTP_W{`PPC_LATCH_RST}};
      end else if (rtTrigger) begin
         trig_sync_out_nxt = rtPrepData;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         trig_sync_out_r <= {RTP_W{`PPC_LATCH_RST}};
      end else begin
         trig_sync_out_r <= trig_sync_out_nxt;
      end
   end

   // One mode bit serves both analog lines, so they can never split
   assign anaCtl = in_ctrl(anaCtrlMode, sysRstSeen_r);

   genvar i;

   generate
      for (i = 0; i < TMR_W; i++) begin : gTmr
         assign tmrCtl[i] = in_ctrl(timerCtrlMode[i], sysRstSeen_r);
         assign timerPortOe[i] = drive_en(tmrCtl[i], timerDir[i]);
         assign timerPortOut[i] = tmrCtl[i] ? timer_wave_out[i]
                                            : timerLatch[i];
         assign timerPortPullUp[i] = timerPullUpEn[i];
         assign timer_ext_clk_in[i] = tmrCtl[i] & tmrIn_r[i];
         assign timerReadData[i] = read_back(timerPortOe[i],
                                             timerPortOut[i],
                                             tmrIn_r[i]);
      end
   endgenerate

   generate
      for (i = 0; i < RTP_W; i++) begin : gRtp
         assign rtCtl[i] = in_ctrl(rtCtrlMode[i], sysRstSeen_r);
         assign realtimePortOe[i] = drive_en(rtCtl[i], rtDir[i]);
         assign realtimePortOut[i] = rtCtl[i] ? trig_sync_out_r[i]
                                              : rtLatch[i];
         assign realtimePortPullUp[i] = rtPullUpEn[i];
         // Owned lines read zero, so pending data never leaks to software
         assign rtReadData[i] = rtCtl[i] ? `PPC_RD_ZERO
                              : read_back(~rtDir[i], rtLatch[i], rtIn_r[i]);
      end
   endgenerate

   generate
      for (i = 0; i < ANA_W; i++) begin : gAna
         assign dacOutEn[i] = anaCtl;
         assign analogPortOe[i] = ~anaCtl
                                & ~analog_port_dir_bit[i];
         assign analogPortOut[i] = anaLatch[i];
         // Read is undefined here; the raw pin sample costs nothing extra
         assign anaReadData[i] = anaCtl ? anaIn_r[i]
                               : read_back(analogPortOe[i], anaLatch[i],
                                           anaIn_r[i]);
      end
   endgenerate

   // No pull-up path exists on the analog lines
   // Parking a spare converter line is left to software
endmodule

/* File: include/ppc_map.svh */
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
`define PPC_TMR_W 4
`define PPC_RTP_W 8
`define PPC_ANA_W 2
`define PPC_DIR_RST 1'b1
`define PPC_LATCH_RST 1'b0
`define PPC_PU_RST 1'b0
`define PPC_MODE_RST 1'b0
`define PPC_RD_ZERO 1'b0
`define PPC_CHIPRST_RST 1'b1
`define PPC_PIN_RST 1'b0
`endif

/* File: include/ppc_pkg.sv */
package ppc_pkg;
   typedef enum logic [0:0] {
      PPC_PORT_MODE = 1'b0,
      PPC_CTRL_MODE = 1'b1
   } ppc_mode_t;
endpackage

/* File: test/ppc_pin_model.sv */
`timescale 1ns/1ps
module ppc_pin_model (
   input wire logic [3:0] out,
   input wire logic [3:0] oe,
   input wire logic [3:0] pu,
   output logic [3:0] pin
);
   // Board holds released lines low, so only a pull-up can read as 1
   assign pin = (oe & out) | (~oe & pu);
endmodule

/* File: test/ppc_port_chk.sv */
`timescale 1ns/1ps
module ppc_port_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic sysResetN,
   input wire logic chipReset,
   input wire logic rtTrigger,
   input wire logic anaCtrlMode,
   input wire logic [7:0] rtCtrlMode,
   input wire logic [7:0] rtPrepData,
   input wire logic [7:0] realtimePortOut,
   input wire logic [7:0] rtReadData,
   input wire logic [1:0] dacOutEn
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence run_s;
      !chipReset ##1 !chipReset && $stable(rtCtrlMode);
   endsequence
   AST_RST: assert property (
      !sysResetN |-> ##[1:2] chipReset) else $error("reset lost");
   AST_RUN: assert property (
      sysResetN [*3] |=> !chipReset) else $error("reset stuck");
   AST_RDAC: assert property (
      chipReset |-> dacOutEn == 2'h0) else $error("dac in reset");
   AST_RD0: assert property (
      !chipReset |-> (rtReadData & rtCtrlMode) == 8'h00) else $error("read");
   AST_LOAD: assert property (rtTrigger ##0 run_s |->
      ((realtimePortOut ^ $past(rtPrepData)) & rtCtrlMode) == 8'h00)
      else $error("load");
   AST_HOLD: assert property (!rtTrigger ##0 run_s |->
      $stable(realtimePortOut & rtCtrlMode)) else $error("hold");
   AST_DACON: assert property (
      anaCtrlMode && !chipReset |-> dacOutEn == 2'h3) else $error("dac on");
   AST_DACOFF: assert property (
      !anaCtrlMode |-> dacOutEn == 2'h0) else $error("dac off");
endmodule
bind ppc_port_ctrl ppc_port_chk chk (.*);

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic clock = '0, rst = '1, sysResetN = '0, rtTrigger = '0, chipReset;
   logic anaCtrlMode = '0;
   logic [3:0] timerDir = '1, timerLatch = '0, timerPullUpEn = '0;
   logic [3:0] timerCtrlMode = '0, timer_wave_out = '0, timerPortIn;
   logic [3:0] timerPortOut, timerPortOe, timerPortPullUp, timerReadData;
   logic [3:0] timer_ext_clk_in;
   logic [7:0] rtDir = '1, rtLatch = '0, rtPullUpEn = '0, rtCtrlMode = '0;
   logic [7:0] rtPrepData = '0, realtimePortIn = '0, realtimePortOut;
   logic [7:0] realtimePortOe, realtimePortPullUp, rtReadData;
   logic [1:0] analog_port_dir_bit = '1, anaLatch = '0, analogPortIn = '0;
   logic [1:0] analogPortOut, analogPortOe, dacOutEn, anaReadData;
   int bad_count = 0, n_checks = 0;
   ppc_port_ctrl dut (.*);
   ppc_pin_model pins (.out(timerPortOut), .oe(timerPortOe),
      .pu(timerPortPullUp), .pin(timerPortIn));
   initial forever #25 clock = ~clock;
   task automatic chk(logic [7:0] got, logic [7:0] exp, string nm);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (n_checks > 0 && bad_count == 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic port_mode();
      @(posedge clock);
      {timerDir, timerLatch, timerPullUpEn} <= {4'h5, 4'hA, 4'h3};
      analog_port_dir_bit <= 2'h2;
      realtimePortIn <= 8'h96;
      repeat (3) @(posedge clock);
      #1;
      chk({timerPortOe, timerReadData}, 8'hAB, "tmr");
      chk({analogPortOe, timerPortPullUp}, 8'h13, "oe_pu");
      chk(rtReadData, 8'h96, "rt_in");
   endtask
   task automatic ctrl_mode();
      @(posedge clock);
      {timerCtrlMode, timer_wave_out, rtTrigger} <= {4'h6, 4'h4, 1'b1};
      {rtDir, rtLatch, rtCtrlMode} <= {8'h00, 8'h3C, 8'hF0};
      rtPrepData <= 8'hA5;
      rtPullUpEn <= 8'h81;
      @(posedge clock);
      {rtTrigger, rtPrepData} <= {1'b0, 8'h5A};
      repeat (2) @(posedge clock);
      #1;
      chk(realtimePortOut, 8'hAC, "rt_out");
      chk(rtReadData, 8'h0C, "rt_rd");
      chk({4'h0, timerPortOut & 4'h6}, 8'h04, "wave");
      chk({4'h0, timer_ext_clk_in}, 8'h04, "ext_clk");
      chk(realtimePortPullUp, 8'h81, "rt_pu");
      chk(realtimePortOe, 8'hFF, "rt_oe");
   endtask
   task automatic ana_spare();
      @(posedge clock);
      analog_port_dir_bit <= 2'h2;
      anaLatch <= 2'h0;
      analogPortIn <= 2'h2;
      repeat (2) @(posedge clock);
      #1;
      chk({2'h0, analogPortOe, analogPortOut, anaReadData},
         8'h12, "spare");
   endtask
   task automatic ana_reset();
      @(posedge clock);
      anaCtrlMode <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk({6'h00, dacOutEn}, 8'h03, "dac");
      @(posedge clock);
      sysResetN <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk({5'h00, chipReset, dacOutEn}, 8'h04, "reset");
   endtask
   initial begin
      repeat (200) @(posedge clock);
      bad_count++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge clock);
      {rst, sysResetN} <= 2'h1;
      repeat (3) @(posedge clock);
      port_mode();
      ctrl_mode();
      ana_spare();
      ana_reset();
      report_and_stop();
   end
endmodule
